// ==== logic/timer_pair_pkg.sv ====
// Constants, register map and field layout of the timer pair
package timer_pair_pkg;
  localparam int          ADDR_W            = 12;
  localparam logic [11:0] OFF_WIDTH_CFG     = 12'h000;
  localparam logic [11:0] OFF_SIDE_A_MODE   = 12'h004;
  localparam logic [11:0] OFF_SIDE_B_MODE   = 12'h008;
  localparam logic [11:0] OFF_CONTROL       = 12'h00C;
  localparam logic [11:0] OFF_FLAG_MASK     = 12'h018;
  localparam logic [11:0] OFF_RAW_FLAG      = 12'h01C;
  localparam logic [11:0] OFF_MASKED_FLAG   = 12'h020;
  localparam logic [11:0] OFF_FLAG_CLEAR    = 12'h024;
  localparam logic [11:0] OFF_SIDE_A_LOAD   = 12'h028;
  localparam logic [11:0] OFF_SIDE_B_LOAD   = 12'h02C;
  localparam logic [11:0] OFF_SIDE_A_MATCH  = 12'h030;
  localparam logic [11:0] OFF_SIDE_A_PRE    = 12'h038;
  localparam logic [11:0] OFF_SIDE_B_PRE    = 12'h03C;
  localparam logic [11:0] OFF_SIDE_A_COUNT  = 12'h048;
  localparam logic [11:0] OFF_SIDE_B_COUNT  = 12'h04C;
  localparam logic [11:0] OFF_PIN_LEVEL     = 12'h050;

  localparam logic [2:0]  CFG_JOINED        = 3'h0;
  localparam logic [2:0]  CFG_CALENDAR      = 3'h1;
  localparam logic [2:0]  CFG_SPLIT         = 3'h4;
  localparam logic [1:0]  MODE_ONE_SHOT     = 2'h1;
  localparam logic [1:0]  MODE_PERIODIC     = 2'h2;

  localparam int          CTL_A_EN          = 0;
  localparam int          CTL_A_FREEZE      = 1;
  localparam int          CTL_CAL_EN        = 4;
  localparam int          CTL_A_TRIG        = 5;
  localparam int          CTL_B_EN          = 8;
  localparam int          CTL_B_FREEZE      = 9;
  localparam int          CTL_B_TRIG        = 13;
  localparam int          FLG_A_TIMEOUT     = 0;
  localparam int          FLG_CAL_MATCH     = 3;
  localparam int          FLG_B_TIMEOUT     = 8;

  localparam logic [15:0] COUNT16_RESET     = 16'hFFFF;
  localparam logic [7:0]  PRESCALE_RESET    = 8'h00;
  localparam logic [31:0] CAL_START         = 32'h00000001;
  localparam int          CAL_EDGES_PER_SEC = 32768;
endpackage

// ==== logic/prescale_step.sv ====
// Prescale divider giving one step every value+1 clocks
`timescale 1ns/1ns
module prescale_step
  import timer_pair_pkg::*;
#(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         run_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              step_o
);
  logic [W-1:0] pre;

  assign step_o = run_i && (pre == '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre <= W'(PRESCALE_RESET);
    end else if (load_i || step_o) begin
      pre <= value_i;
    end else if (run_i) begin
      pre <= pre - 1'b1;
    end
  end
endmodule

// ==== logic/second_tick.sv ====
// Capture-pin clock synchroniser and edge divider to one tick a second
`timescale 1ns/1ns
module second_tick
  import timer_pair_pkg::*;
#(
  parameter int DIV = CAL_EDGES_PER_SEC
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic run_i,
  output logic      level_o,
  output logic      tick_o
);
  localparam int CW = $clog2(DIV);
  logic          sync1;
  logic          sync2;
  logic          last;
  logic [CW-1:0] edges;
  logic          rise;

  assign level_o = sync2;
  assign rise    = sync2 && !last;

  // Second stage feeds both the edge detector and the level output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last  <= 1'b0;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      last  <= sync2;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edges  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= 1'b0;
      if (!run_i) begin
        edges <= '0;
      end else if (rise) begin
        if (edges == CW'(DIV - 1)) begin
          edges  <= '0;
          tick_o <= 1'b1;
        end else begin
          edges <= edges + 1'b1;
        end
      end
    end
  end
endmodule

// ==== logic/timer_pair.sv ====
// Timer pair top: APB registers, joined and split counters, flags, trigger
`timescale 1ns/1ns
module timer_pair
  import timer_pair_pkg::*;
#(
  parameter int CAL_DIV = CAL_EDGES_PER_SEC
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESETN_I,
  input  wire logic              PSEL_I,
  input  wire logic              PENABLE_I,
  input  wire logic              PWRITE_I,
  input  wire logic [ADDR_W-1:0] PADDR_I,
  input  wire logic [31:0]       PWDATA_I,
  output logic      [31:0]       PRDATA_O,
  output logic                   PREADY_O,
  output logic                   PSLVERR_O,
  input  wire logic              CAPTURE_PIN_EVEN_I,
  input  wire logic              CAPTURE_PIN_ODD_I,
  input  wire logic              TRIGGER_CHAIN_I,
  output logic                   CONVERTER_TRIGGER_O,
  output logic                   INTERRUPT_O
);
  logic [2:0]  width_config_reg;
  logic [1:0]  side_a_mode_field;
  logic [1:0]  side_b_mode_field;
  logic        side_a_enable;
  logic        side_b_enable;
  logic        side_a_freeze;
  logic        side_b_freeze;
  logic        side_a_trigger_enable;
  logic        side_b_trigger_enable;
  logic        calendar_count_enable;
  logic [2:0]  flag_mask_reg;
  logic [2:0]  raw_flag_reg;
  logic [15:0] side_a_interval_load;
  logic [15:0] side_b_interval_load;
  logic [7:0]  side_a_prescale;
  logic [7:0]  side_b_prescale;
  logic [31:0] side_a_match_value;
  logic [15:0] side_a_count_value;
  logic [15:0] side_b_count_value;
  logic        calendar_seen;
  logic        odd_level;

  logic        bus_write;
  logic        bus_setup_read;
  logic        addr_ok;
  logic [31:0] read_word;
  logic        joined;
  logic        calendar;
  logic        split;
  logic [31:0] count32;
  logic        even_level;
  logic        sec_tick;
  logic        step_a;
  logic        step_b;
  logic        run_a;
  logic        run_b;
  logic        reload_a;
  logic        reload_b;

  logic [15:0] next_count_a;
  logic [15:0] next_count_b;
  logic        next_trig_a;
  logic        next_trig_b;
  logic        timeout_a;
  logic        timeout_b;
  logic        cal_match;
  logic        stop_a;
  logic        stop_b;
  logic [2:0]  next_raw_flag;

  function automatic logic [31:0] flags_to_bus(input logic [2:0] f);
    logic [31:0] w;
    w                = 32'h00000000;
    w[FLG_A_TIMEOUT] = f[0];
    w[FLG_CAL_MATCH] = f[1];
    w[FLG_B_TIMEOUT] = f[2];
    return w;
  endfunction

  function automatic logic [2:0] bus_to_flags(input logic [31:0] w);
    return {w[FLG_B_TIMEOUT], w[FLG_CAL_MATCH], w[FLG_A_TIMEOUT]};
  endfunction

  function automatic logic wr_at(input logic       wr,
                                 input logic [11:0] addr,
                                 input logic [11:0] off);
    return wr && (addr == off);
  endfunction

  assign joined   = (width_config_reg == CFG_JOINED);
  assign calendar = (width_config_reg == CFG_CALENDAR);
  assign split    = (width_config_reg == CFG_SPLIT);
  assign count32  = {side_b_count_value, side_a_count_value};

  // Write lands at the access edge where ready is already high
  assign bus_write      = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O;
  assign bus_setup_read = PSEL_I && !PENABLE_I && !PWRITE_I;

  // Only the even pin feeds the calendar clock
  second_tick #(
    .DIV(CAL_DIV)
  ) u_second (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .pin_i   (CAPTURE_PIN_EVEN_I),
    .run_i   (calendar && side_a_enable),
    .level_o (even_level),
    .tick_o  (sec_tick)
  );

  assign run_a    = split && side_a_enable && !side_a_freeze;
  assign run_b    = split && side_b_enable && !side_b_freeze;
  assign reload_a = run_a && (side_a_count_value == 16'h0000);
  assign reload_b = run_b && (side_b_count_value == 16'h0000);

  prescale_step #(
    .W(8)
  ) u_pre_a (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .run_i   (run_a),
    .load_i  (reload_a || wr_at(bus_write, PADDR_I, OFF_SIDE_A_LOAD)),
    .value_i (side_a_prescale),
    .step_o  (step_a)
  );

  prescale_step #(
    .W(8)
  ) u_pre_b (
    .clk_i   (SYS_CLK_I),
    .rst_n_i (RESETN_I),
    .run_i   (run_b),
    .load_i  (reload_b || wr_at(bus_write, PADDR_I, OFF_SIDE_B_LOAD)),
    .value_i (side_b_prescale),
    .step_o  (step_b)
  );

  // Counting for all three widths in one place
  always_comb begin
    logic [31:0] n32;
    n32          = count32;
    next_count_a = side_a_count_value;
    next_count_b = side_b_count_value;
    next_trig_a  = 1'b0;
    next_trig_b  = 1'b0;
    timeout_a    = 1'b0;
    timeout_b    = 1'b0;
    cal_match    = 1'b0;
    stop_a       = 1'b0;
    stop_b       = 1'b0;
    if (joined && side_a_enable && !side_a_freeze) begin
      if (count32 == 32'h00000000) begin
        n32       = {side_b_interval_load, side_a_interval_load};
        timeout_a = 1'b1;
        stop_a    = (side_a_mode_field == MODE_ONE_SHOT);
      end else begin
        n32         = count32 - 32'h00000001;
        next_trig_a = (count32 == 32'h00000001);
      end
      next_count_a = n32[15:0];
      next_count_b = n32[31:16];
    end else if (calendar && side_a_enable && sec_tick &&
                 (calendar_count_enable || !(side_a_freeze || side_b_freeze))) begin
      if (count32 == side_a_match_value) begin
        n32       = 32'h00000000;
        cal_match = 1'b1;
      end else begin
        n32 = count32 + 32'h00000001;
      end
      next_count_a = n32[15:0];
      next_count_b = n32[31:16];
    end
    if (reload_a) begin
      next_count_a = side_a_interval_load;
      timeout_a    = 1'b1;
      stop_a       = (side_a_mode_field == MODE_ONE_SHOT);
    end else if (step_a) begin
      next_count_a = side_a_count_value - 16'h0001;
      next_trig_a  = (side_a_count_value == 16'h0001);
    end
    if (reload_b) begin
      next_count_b = side_b_interval_load;
      timeout_b    = 1'b1;
      stop_b       = (side_b_mode_field == MODE_ONE_SHOT);
    end else if (step_b) begin
      next_count_b = side_b_count_value - 16'h0001;
      next_trig_b  = (side_b_count_value == 16'h0001);
    end
    next_trig_a = next_trig_a && side_a_trigger_enable;
    next_trig_b = next_trig_b && side_b_trigger_enable && split;
  end

  // Set wins over a clear in the same cycle
  always_comb begin
    next_raw_flag = raw_flag_reg;
    if (wr_at(bus_write, PADDR_I, OFF_FLAG_CLEAR)) begin
      next_raw_flag = raw_flag_reg & ~bus_to_flags(PWDATA_I);
    end
    next_raw_flag = next_raw_flag | {timeout_b, cal_match, timeout_a};
  end

  always_comb begin
    addr_ok   = 1'b1;
    read_word = 32'h00000000;
    unique case (PADDR_I)
      OFF_WIDTH_CFG:    read_word = {29'h0, width_config_reg};
      OFF_SIDE_A_MODE:  read_word = {30'h0, side_a_mode_field};
      OFF_SIDE_B_MODE:  read_word = {30'h0, side_b_mode_field};
      OFF_CONTROL: begin
        read_word[CTL_A_EN]     = side_a_enable;
        read_word[CTL_A_FREEZE] = side_a_freeze;
        read_word[CTL_CAL_EN]   = calendar_count_enable;
        read_word[CTL_A_TRIG]   = side_a_trigger_enable;
        read_word[CTL_B_EN]     = side_b_enable;
        read_word[CTL_B_FREEZE] = side_b_freeze;
        read_word[CTL_B_TRIG]   = side_b_trigger_enable;
      end
      OFF_FLAG_MASK:    read_word = flags_to_bus(flag_mask_reg);
      OFF_RAW_FLAG:     read_word = flags_to_bus(raw_flag_reg);
      OFF_MASKED_FLAG:  read_word = flags_to_bus(raw_flag_reg & flag_mask_reg);
      OFF_FLAG_CLEAR:   read_word = 32'h00000000;
      OFF_SIDE_A_LOAD:  read_word = split ? {16'h0, side_a_interval_load}
                                          : {side_b_interval_load, side_a_interval_load};
      OFF_SIDE_B_LOAD:  read_word = {16'h0, side_b_interval_load};
      OFF_SIDE_A_MATCH: read_word = side_a_match_value;
      OFF_SIDE_A_PRE:   read_word = {24'h0, side_a_prescale};
      OFF_SIDE_B_PRE:   read_word = {24'h0, side_b_prescale};
      OFF_SIDE_A_COUNT: read_word = split ? {16'h0, side_a_count_value} : count32;
      OFF_SIDE_B_COUNT: read_word = {16'h0, side_b_count_value};
      OFF_PIN_LEVEL:    read_word = {30'h0, odd_level && split, even_level};
      default:          addr_ok = 1'b0;
    endcase
  end

  // Bus answer: ready on the second access cycle, data latched at setup
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      PREADY_O  <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O  <= 32'h00000000;
    end else begin
      PREADY_O  <= PSEL_I && PENABLE_I && !PREADY_O;
      PSLVERR_O <= PSEL_I && PENABLE_I && !PREADY_O && !addr_ok;
      if (bus_setup_read) begin
        PRDATA_O <= addr_ok ? read_word : 32'h00000000;
      end
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      width_config_reg  <= CFG_JOINED;
      side_a_mode_field <= 2'h0;
      side_b_mode_field <= 2'h0;
      flag_mask_reg     <= 3'h0;
      side_a_match_value <= 32'h00000000;
      side_a_prescale   <= PRESCALE_RESET;
      side_b_prescale   <= PRESCALE_RESET;
    end else begin
      if (wr_at(bus_write, PADDR_I, OFF_WIDTH_CFG)) begin
        width_config_reg <= PWDATA_I[2:0];
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_A_MODE)) begin
        side_a_mode_field <= PWDATA_I[1:0];
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_B_MODE)) begin
        side_b_mode_field <= PWDATA_I[1:0];
      end
      if (wr_at(bus_write, PADDR_I, OFF_FLAG_MASK)) begin
        flag_mask_reg <= bus_to_flags(PWDATA_I);
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_A_MATCH)) begin
        side_a_match_value <= PWDATA_I;
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_A_PRE)) begin
        side_a_prescale <= PWDATA_I[7:0];
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_B_PRE)) begin
        side_b_prescale <= PWDATA_I[7:0];
      end
    end
  end

  // A software write to control wins over a one-shot self clear
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      side_a_enable         <= 1'b0;
      side_b_enable         <= 1'b0;
      side_a_freeze         <= 1'b0;
      side_b_freeze         <= 1'b0;
      side_a_trigger_enable <= 1'b0;
      side_b_trigger_enable <= 1'b0;
      calendar_count_enable <= 1'b0;
    end else if (wr_at(bus_write, PADDR_I, OFF_CONTROL)) begin
      side_a_enable         <= PWDATA_I[CTL_A_EN];
      side_b_enable         <= PWDATA_I[CTL_B_EN];
      side_a_freeze         <= PWDATA_I[CTL_A_FREEZE];
      side_b_freeze         <= PWDATA_I[CTL_B_FREEZE];
      side_a_trigger_enable <= PWDATA_I[CTL_A_TRIG];
      side_b_trigger_enable <= PWDATA_I[CTL_B_TRIG];
      calendar_count_enable <= PWDATA_I[CTL_CAL_EN];
    end else begin
      if (stop_a) begin
        side_a_enable <= 1'b0;
      end
      if (stop_b) begin
        side_b_enable <= 1'b0;
      end
    end
  end

  // Load writes reach the count at once, running or not
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      side_a_interval_load <= COUNT16_RESET;
      side_b_interval_load <= COUNT16_RESET;
      side_a_count_value   <= COUNT16_RESET;
      side_b_count_value   <= COUNT16_RESET;
      calendar_seen        <= 1'b0;
    end else begin
      side_a_count_value <= next_count_a;
      side_b_count_value <= next_count_b;
      if (wr_at(bus_write, PADDR_I, OFF_WIDTH_CFG) && PWDATA_I[2:0] == CFG_CALENDAR &&
          !calendar_seen) begin
        calendar_seen      <= 1'b1;
        side_a_count_value <= CAL_START[15:0];
        side_b_count_value <= CAL_START[31:16];
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_A_LOAD)) begin
        side_a_interval_load <= PWDATA_I[15:0];
        side_a_count_value   <= PWDATA_I[15:0];
        if (!split) begin
          side_b_interval_load <= PWDATA_I[31:16];
          side_b_count_value   <= PWDATA_I[31:16];
        end
      end
      if (wr_at(bus_write, PADDR_I, OFF_SIDE_B_LOAD)) begin
        side_b_interval_load <= PWDATA_I[15:0];
        side_b_count_value   <= PWDATA_I[15:0];
      end
    end
  end

  // Chain input lets several blocks share one converter line
  always_ff @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      raw_flag_reg        <= 3'h0;
      INTERRUPT_O         <= 1'b0;
      CONVERTER_TRIGGER_O <= 1'b0;
      odd_level           <= 1'b0;
    end else begin
      raw_flag_reg        <= next_raw_flag;
      INTERRUPT_O         <= |(next_raw_flag & flag_mask_reg);
      CONVERTER_TRIGGER_O <= next_trig_a || next_trig_b || TRIGGER_CHAIN_I;
      odd_level           <= CAPTURE_PIN_ODD_I;
    end
  end
endmodule

// ==== verification/timer_pair_sva.sv ====
// Port-level checker for the timer pair
`timescale 1ns/1ns
module timer_pair_sva
  import timer_pair_pkg::*;
#(
  parameter int CAL_DIV = CAL_EDGES_PER_SEC
) (
  input wire logic              SYS_CLK_I,
  input wire logic              RESETN_I,
  input wire logic              PSEL_I,
  input wire logic              PENABLE_I,
  input wire logic              PWRITE_I,
  input wire logic [ADDR_W-1:0] PADDR_I,
  input wire logic [31:0]       PWDATA_I,
  input wire logic [31:0]       PRDATA_O,
  input wire logic              PREADY_O,
  input wire logic              PSLVERR_O,
  input wire logic              CAPTURE_PIN_EVEN_I,
  input wire logic              CAPTURE_PIN_ODD_I,
  input wire logic              TRIGGER_CHAIN_I,
  input wire logic              CONVERTER_TRIGGER_O,
  input wire logic              INTERRUPT_O
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  ready_timing_a: assert property ($rose(PENABLE_I) && PSEL_I |=> PREADY_O)
    else $error("ready missed second access cycle");
  ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
    else $error("ready outside access phase");
  error_ready_a: assert property (PSLVERR_O |-> PREADY_O)
    else $error("error without ready");
  // Read data may only move after a read setup edge
  data_hold_a: assert property (!$stable(PRDATA_O) |->
    $past(PSEL_I && !PENABLE_I && !PWRITE_I))
    else $error("read data moved without read setup");
  chain_or_a: assert property (TRIGGER_CHAIN_I |=> CONVERTER_TRIGGER_O)
    else $error("chained trigger lost");
  trig_pulse_a: assert property (CONVERTER_TRIGGER_O && !TRIGGER_CHAIN_I &&
    !$past(TRIGGER_CHAIN_I) |=> !CONVERTER_TRIGGER_O)
    else $error("own trigger wider than one cycle");
  // A clear write drops it one edge after the write, a mask write one edge later
  irq_clear_a: assert property ($fell(INTERRUPT_O) |->
    $past(PREADY_O && PWRITE_I) || $past(PREADY_O && PWRITE_I, 2))
    else $error("interrupt dropped without a write");
  own_trig_c: cover property (CONVERTER_TRIGGER_O && !$past(TRIGGER_CHAIN_I));
  irq_rise_c: cover property ($rose(INTERRUPT_O));
  slverr_c: cover property (PSLVERR_O);
endmodule

bind timer_pair timer_pair_sva #(.CAL_DIV(CAL_DIV)) u_sva (
  .SYS_CLK_I(SYS_CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
  .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .CAPTURE_PIN_EVEN_I(CAPTURE_PIN_EVEN_I),
  .CAPTURE_PIN_ODD_I(CAPTURE_PIN_ODD_I), .TRIGGER_CHAIN_I(TRIGGER_CHAIN_I),
  .CONVERTER_TRIGGER_O(CONVERTER_TRIGGER_O), .INTERRUPT_O(INTERRUPT_O));

// ==== verification/capture_source.sv ====
// Far-side model: capture clock source and odd capture level
`timescale 1ns/1ns
module capture_source #(
  parameter int HALF_NS = 110
) (
  input  wire logic run_i,
  input  wire logic odd_i,
  output logic      even_o,
  output logic      odd_o
);
  // Scaled stand-in for the slow clock, so a run stays short
  initial begin
    even_o = 1'b0;
    forever begin
      wait (run_i);
      #HALF_NS even_o = 1'b1;
      #HALF_NS even_o = 1'b0;
    end
  end
  assign odd_o = odd_i;
endmodule

// ==== verification/test_timer_pair.sv ====
// Self-checking bench for the timer pair
`timescale 1ns/1ns
module test_timer_pair;
  import timer_pair_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        even;
  logic        odd;
  logic        odd_drv;
  logic        chain;
  logic        trig;
  logic        irq;
  logic        run;
  logic [31:0] q;
  logic [31:0] c;
  logic        err;
  int          n;
  int          fails;
  int          checks;

  timer_pair #(.CAL_DIV(4)) dut (
    .SYS_CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .CAPTURE_PIN_EVEN_I(even), .CAPTURE_PIN_ODD_I(odd),
    .TRIGGER_CHAIN_I(chain), .CONVERTER_TRIGGER_O(trig), .INTERRUPT_O(irq));
  capture_source src (.run_i(run), .odd_i(odd_drv), .even_o(even), .odd_o(odd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Entered just after a rising edge; one idle cycle follows each transfer
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask

  task automatic hi(input logic irq_sel);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((irq_sel ? irq : trig) !== 1'b1);
  endtask

  task automatic t_reset;
    rc("cfg", OFF_WIDTH_CFG, 32'h0);
    rc("ctl", OFF_CONTROL, 32'h0);
    rc("a_load", OFF_SIDE_A_LOAD, 32'hFFFFFFFF);
    rc("a_count", OFF_SIDE_A_COUNT, 32'hFFFFFFFF);
    rc("b_load", OFF_SIDE_B_LOAD, 32'h0000FFFF);
    rc("b_count", OFF_SIDE_B_COUNT, 32'h0000FFFF);
    rc("a_pre", OFF_SIDE_A_PRE, 32'h0);
    rc("b_pre", OFF_SIDE_B_PRE, 32'h0);
    apb(1'b0, 12'hFFC, 32'h0);
    chk("unmapped", 32'h1, err);
    chain <= 1'b1;
    @(posedge clk);
    chain <= 1'b0;
    @(posedge clk);
    chk("chain", 32'h1, trig);
    $display("reset test done");
  endtask

  task automatic t_joined;
    wr(OFF_SIDE_A_MODE, MODE_ONE_SHOT);
    wr(OFF_SIDE_A_LOAD, 32'h12345678);
    rc("a_load", OFF_SIDE_A_LOAD, 32'h12345678);
    rc("b_load", OFF_SIDE_B_LOAD, 32'h00001234);
    rc("a_count", OFF_SIDE_A_COUNT, 32'h12345678);
    wr(OFF_SIDE_A_LOAD, 32'h20);
    wr(OFF_FLAG_MASK, 32'h1);
    wr(OFF_CONTROL, 32'h21);
    hi(1'b0);
    rc("ctl", OFF_CONTROL, 32'h20);
    rc("a_count", OFF_SIDE_A_COUNT, 32'h20);
    rc("raw", OFF_RAW_FLAG, 32'h1);
    rc("masked", OFF_MASKED_FLAG, 32'h1);
    chk("irq", 32'h1, irq);
    wr(OFF_FLAG_CLEAR, 32'h1);
    rc("raw", OFF_RAW_FLAG, 32'h0);
    chk("irq", 32'h0, irq);
    wr(OFF_SIDE_A_MODE, MODE_PERIODIC);
    wr(OFF_SIDE_A_LOAD, 32'h10);
    wr(OFF_CONTROL, 32'h21);
    hi(1'b0);
    hi(1'b0);
    chk("period", 32'h11, n);
    wr(OFF_SIDE_A_LOAD, 32'h100);
    apb(1'b0, OFF_SIDE_A_COUNT, 32'h0);
    chk("new_load", 32'h1, q > 32'h10 && q <= 32'h100);
    wr(OFF_CONTROL, 32'h23);
    apb(1'b0, OFF_SIDE_A_COUNT, 32'h0);
    c = q;
    rc("frozen", OFF_SIDE_A_COUNT, c);
    wr(OFF_CONTROL, 32'h21);
    apb(1'b0, OFF_SIDE_A_COUNT, 32'h0);
    chk("resumed", 32'h1, q != c);
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_FLAG_CLEAR, 32'h1);
    $display("joined test done");
  endtask

  task automatic t_split;
    wr(OFF_WIDTH_CFG, CFG_SPLIT);
    wr(OFF_SIDE_A_MODE, MODE_PERIODIC);
    wr(OFF_SIDE_B_MODE, MODE_ONE_SHOT);
    wr(OFF_SIDE_A_PRE, 32'h3);
    wr(OFF_SIDE_A_LOAD, 32'h5);
    wr(OFF_SIDE_B_LOAD, 32'h9);
    rc("a_pre", OFF_SIDE_A_PRE, 32'h3);
    wr(OFF_FLAG_MASK, 32'h100);
    odd_drv <= 1'b1;
    wr(OFF_CONTROL, 32'h121);
    hi(1'b0);
    hi(1'b0);
    chk("period", 32'h15, n);
    rc("ctl", OFF_CONTROL, 32'h21);
    rc("b_count", OFF_SIDE_B_COUNT, 32'h9);
    rc("raw", OFF_RAW_FLAG, 32'h101);
    chk("irq", 32'h1, irq);
    rc("pins", OFF_PIN_LEVEL, 32'h2);
    wr(OFF_CONTROL, 32'h2100);
    hi(1'b0);
    chk("b_trig", 32'h9, n);
    rc("b_stop", OFF_CONTROL, 32'h2000);
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_FLAG_CLEAR, 32'h109);
    wr(OFF_WIDTH_CFG, CFG_JOINED);
    rc("pins", OFF_PIN_LEVEL, 32'h0);
    $display("split test done");
  endtask

  task automatic t_calendar;
    wr(OFF_WIDTH_CFG, CFG_CALENDAR);
    rc("start", OFF_SIDE_A_COUNT, CAL_START);
    wr(OFF_SIDE_A_MATCH, 32'h3);
    wr(OFF_FLAG_MASK, 32'h8);
    wr(OFF_CONTROL, 32'h13);
    run <= 1'b1;
    hi(1'b1);
    rc("rolled", OFF_SIDE_A_COUNT, 32'h0);
    rc("raw", OFF_RAW_FLAG, 32'h8);
    rc("masked", OFF_MASKED_FLAG, 32'h8);
    run <= 1'b0;
    wr(OFF_CONTROL, 32'h0);
    wr(OFF_FLAG_CLEAR, 32'h8);
    rc("raw", OFF_RAW_FLAG, 32'h0);
    $display("calendar test done");
  endtask

  task automatic stop_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles; this is far beyond it
  initial begin
    #800000;
    fails++;
    stop_test;
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    odd_drv = 1'b0;
    chain = 1'b0;
    run = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_joined;
    t_split;
    t_calendar;
    stop_test;
  end
endmodule
